// file: logic/usr_pkg.sv
// Purpose: Shared constants and types of the serial unit register block.
// Assumes: APB with 32-bit data, one register per aligned word.
// Notes:   Byte address of a register is four times its index.
`default_nettype none
package usr_pkg;
   // ****************************************
   // Register indices and bus width
   // ****************************************
   localparam int ADDR_W = 8;
   localparam logic [5:0] IDX_MAIN = 6'h00;
   localparam logic [5:0] IDX_SEC = 6'h04;
   localparam logic [5:0] IDX_BAUD = 6'h0c;
   localparam logic [5:0] IDX_RECEIVE_PULSE_LENGTH = 6'h0e;
   localparam logic [5:0] IDX_IEC = 6'h14;
   localparam logic [5:0] IDX_IES = 6'h16;
   localparam logic [5:0] IDX_FLAG = 6'h18;
   localparam logic [5:0] IDX_STAT = 6'h1a;
   localparam logic [5:0] IDX_SYNC = 6'h1c;
   localparam logic [5:0] IDX_DATA = 6'h28;
   localparam logic [5:0] IDX_DBG = 6'h30;
   // ****************************************
   // Reset values and writable masks
   // ****************************************
   localparam logic [31:0] MAIN_RST = 32'h00000000;
   localparam logic [31:0] MAIN_WMASK = 32'h7ff3e19f;
   localparam logic [31:0] SEC_WMASK = 32'h00032747;
   localparam logic [31:0] EN_FREE = 32'h00000003;
   localparam logic [31:0] RXTX_MASK = 32'h00030000;
   localparam logic [7:0] FLAG_MASK = 8'hbf;
   // ****************************************
   // Field positions
   // ****************************************
   localparam int B_SWRST = 0;
   localparam int B_ENABLE = 1;
   localparam int B_COMM_MODE_SELECT = 28;
   localparam int B_SERIAL_CLOCK_POLARITY = 29;
   localparam int B_BIT_ORDER_SELECT = 30;
   localparam int B_TXEN = 16;
   localparam int B_RXEN = 17;
   localparam int F_DRE = 0;
   localparam int F_TXC = 1;
   localparam int F_RXC = 2;
   localparam int F_RXS = 3;
   localparam int F_CLEAR_TO_SEND_CHANGE = 4;
   localparam int F_ERR = 7;
   localparam int ST_BUFOVF = 2;
   localparam int SY_SWRST = 0;
   localparam int SY_EN = 1;
   localparam int SY_SECONDARY_CONTROL = 2;
   // ****************************************
   // Timing and states
   // ****************************************
   localparam logic [2:0] SYNC_CYCLES = 3'd3;
   // Edges after reset before a synchronised pin level can be trusted
   localparam logic [2:0] PIN_SETTLE = 3'd5;
   typedef enum logic [3:0] {
      ST_IDLE = 4'b0001,
      ST_START = 4'b0010,
      ST_DATA = 4'b0100,
      ST_STOP = 4'b1000
   } usr_state_t;
endpackage : usr_pkg
`default_nettype wire

// file: logic/usr_sync3.sv
// Purpose: Three-stage synchroniser for pin inputs.
// Assumes: Inputs are asynchronous to core_clk.
// Notes:   Output moves only when stages two and three agree.
`timescale 1ns/1ps
`default_nettype none
module usr_sync3 #(
   parameter int W = 3
) (
   input wire logic core_clk,
   input wire logic reset,
   input wire logic clkEn,
   input wire logic [W-1:0] din,
   output logic [W-1:0] dout
);
   typedef struct packed {
      logic [W-1:0] f1;
      logic [W-1:0] f2;
      logic [W-1:0] f3;
      logic [W-1:0] stable;
   } usr_sync_t;
   usr_sync_t q;
   usr_sync_t d;
   logic [W-1:0] agree;

   // First stage feeds only the second stage
   genvar i;
   generate
      for (i = 0; i < W; i++) begin : g_bit
         assign agree[i] = (q.f2[i] == q.f3[i]);
      end
   endgenerate

   // Shift chain and agreement filter
   always_comb begin
      d = q;
      d.f1 = din;
      d.f2 = q.f1;
      d.f3 = q.f2;
      d.stable = (q.stable & ~agree) | (q.f2 & agree);
   end

   // Frozen while clock enable is low
   always_ff @(posedge core_clk or posedge reset) begin
      if (reset) begin
         q <= '0;
      end else if (clkEn) begin
         q <= d;
      end
   end

   assign dout = q.stable;
endmodule : usr_sync3
`default_nettype wire

// file: logic/usr_shift.sv
// Purpose: Eight-bit shift register with selectable bit order.
// Assumes: Load has priority over shift.
// Notes:   Used once for transmit and once for receive.
`timescale 1ns/1ps
`default_nettype none
module usr_shift (
   input wire logic core_clk,
   input wire logic reset,
   input wire logic clkEn,
   input wire logic load,
   input wire logic [7:0] loadVal,
   input wire logic shift,
   input wire logic inBit,
   input wire logic lsbFirst,
   output logic outBit,
   output logic [7:0] word
);
   typedef struct packed {
      logic [7:0] sh;
   } usr_shift_t;
   usr_shift_t q;
   usr_shift_t d;

   // Order decides which end leaves and which end fills
   always_comb begin
      d = q;
      if (load) begin
         d.sh = loadVal;
      end else if (shift) begin
         d.sh = lsbFirst ? {inBit, q.sh[7:1]} : {q.sh[6:0], inBit};
      end
   end

   always_ff @(posedge core_clk or posedge reset) begin
      if (reset) begin
         q <= '0;
      end else if (clkEn) begin
         q <= d;
      end
   end

   assign outBit = lsbFirst ? q.sh[0] : q.sh[7];
   assign word = q.sh;
endmodule : usr_shift
`default_nettype wire

// file: logic/usr_usart.sv
// Purpose: Serial unit with APB register map, frame engine and interrupt.
// Assumes: APB slave with byte strobes, pins synchronised in three stages.
// Notes:   Write-synchronised fields take effect after a short delay.
`timescale 1ns/1ps
`default_nettype none
module usr_usart (
   input wire logic core_clk,
   input wire logic reset,
   input wire logic clkEn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [usr_pkg::ADDR_W-1:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [3:0] pstrb,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic rxd,
   input wire logic ctsPin,
   input wire logic periphAccessLock,
   output logic txd,
   output logic txdOe,
   output logic xck,
   output logic xckOe,
   output logic irq
);
   import usr_pkg::*;

   // ****************************************
   // State
   // ****************************************
   typedef struct packed {
      logic pready;
      logic pslverr;
      logic [31:0] prdata;
      logic [31:0] mainCtl;
      logic [31:0] secCtl;
      logic [15:0] baud;
      logic [7:0] receive_pulse_length;
      logic [7:0] irqEn;
      logic [7:0] irqFlag;
      logic bufOvf;
      logic dbgStop;
      logic [2:0] syncPend;
      logic [2:0] syncCnt;
      logic coreEn;
      logic coreTx;
      logic coreRx;
      logic [7:0] txBuf;
      logic txFull;
      logic [7:0] rxData;
      logic rxFull;
      usr_state_t state;
      logic [3:0] bitCnt;
      logic [15:0] baudCnt;
      logic phase;
      logic txd;
      logic txdOe;
      logic xck;
      logic xckOe;
      logic irq;
      logic ctsLast;
      logic [2:0] settle;
   } usr_core_t;

   localparam usr_core_t CORE_RST = '{state: ST_IDLE, txd: 1'b1, default: '0};

   usr_core_t q;
   usr_core_t d;
   logic [5:0] idx;
   logic [31:0] bm;
   logic answer;
   logic done;
   logic wpS;
   logic ctsS;
   logic rxdS;
   logic txBit;
   logic [7:0] rxWord;
   logic tick;
   logic txLoad;
   logic txShift;
   logic rxShift;
   logic [7:0] evt;
   logic [31:0] nv;
   logic comm_mode_select;
   logic serial_clock_polarity;
   logic bit_order_select;
   logic keepRdy;
   logic keepErr;
   logic [31:0] keepData;

   function automatic logic [31:0] mergeW(input logic [31:0] oldV, input logic [31:0] wrV,
                                          input logic [31:0] bmV);
      return (oldV & ~bmV) | (wrV & bmV);
   endfunction : mergeW

   // Bus decode; each byte strobe opens one lane
   assign idx = paddr[7:2];
   assign bm = {{8{pstrb[3]}}, {8{pstrb[2]}}, {8{pstrb[1]}}, {8{pstrb[0]}}};
   assign answer = psel & penable & ~q.pready;
   assign done = psel & penable & q.pready;
   assign comm_mode_select = q.mainCtl[B_COMM_MODE_SELECT];
   assign serial_clock_polarity = q.mainCtl[B_SERIAL_CLOCK_POLARITY];
   assign bit_order_select = q.mainCtl[B_BIT_ORDER_SELECT];

   // ****************************************
   // Pin synchroniser and shifters
   // ****************************************
   usr_sync3 #(.W(3)) u_sync (
      .core_clk(core_clk),
      .reset(reset),
      .clkEn(clkEn),
      .din({periphAccessLock, ctsPin, rxd}),
      .dout({wpS, ctsS, rxdS})
   );

   usr_shift u_txShift (
      .core_clk(core_clk),
      .reset(reset),
      .clkEn(clkEn),
      .load(txLoad),
      .loadVal(q.txBuf),
      .shift(txShift),
      .inBit(1'b0),
      .lsbFirst(bit_order_select),
      .outBit(txBit),
      .word()
   );

   usr_shift u_rxShift (
      .core_clk(core_clk),
      .reset(reset),
      .clkEn(clkEn),
      .load(1'b0),
      .loadVal(8'h00),
      .shift(rxShift),
      .inBit(rxdS),
      .lsbFirst(bit_order_select),
      .outBit(),
      .word(rxWord)
   );

   // ****************************************
   // Next state
   // ****************************************
   always_comb begin
      d = q;
      tick = 1'b0;
      txLoad = 1'b0;
      txShift = 1'b0;
      rxShift = 1'b0;
      evt = 8'h00;
      nv = 32'h00000000;
      // Sync delay ends: core copies of the fields follow
      if (|q.syncPend) begin
         if (q.syncCnt == 3'd1) begin
            d.syncPend = 3'b000;
            d.syncCnt = 3'd0;
            d.coreEn = q.mainCtl[B_ENABLE];
            d.coreTx = q.secCtl[B_TXEN];
            d.coreRx = q.secCtl[B_RXEN];
         end else begin
            d.syncCnt = q.syncCnt - 3'd1;
         end
      end
      // Answer one cycle into the access phase
      d.pready = answer;
      if (answer) begin
         d.pslverr = 1'b0;
         d.prdata = 32'h00000000;
         case (idx)
            IDX_MAIN: d.prdata = q.mainCtl & MAIN_WMASK;
            IDX_SEC: d.prdata = q.secCtl;
            IDX_BAUD: d.prdata = {16'h0000, q.baud};
            IDX_RECEIVE_PULSE_LENGTH: d.prdata = {24'h000000, q.receive_pulse_length};
            IDX_IEC: d.prdata = {24'h000000, q.irqEn};
            IDX_IES: d.prdata = {24'h000000, q.irqEn};
            IDX_FLAG: d.prdata = {24'h000000, q.irqFlag};
            IDX_STAT: d.prdata = {28'h0000000, ctsS, q.bufOvf, 2'b00};
            IDX_SYNC: d.prdata = {29'h00000000, q.syncPend};
            IDX_DATA: d.prdata = {24'h000000, q.rxData};
            IDX_DBG: d.prdata = {31'h00000000, q.dbgStop};
            default: d.pslverr = 1'b1;
         endcase
         if (pwrite) begin
            // Writes during reset or into a busy field are refused
            if (q.syncPend[SY_SWRST]) begin
               d.pslverr = 1'b1;
            end
            if (wpS && (idx == IDX_MAIN || idx == IDX_SEC || idx == IDX_BAUD
                        || idx == IDX_RECEIVE_PULSE_LENGTH || idx == IDX_DBG)) begin
               d.pslverr = 1'b1;
            end
            if (idx == IDX_MAIN && pstrb[0] && q.syncPend[SY_EN]) begin
               d.pslverr = 1'b1;
            end
            if (idx == IDX_SEC && pstrb[2] && q.syncPend[SY_SECONDARY_CONTROL]) begin
               d.pslverr = 1'b1;
            end
         end
      end
      // Register writes land at the completing edge
      if (done && pwrite && !q.pslverr) begin
         case (idx)
            IDX_MAIN: begin
               nv = mergeW(q.mainCtl, pwdata, bm) & MAIN_WMASK;
               if (q.mainCtl[B_ENABLE]) begin
                  nv = (q.mainCtl & ~EN_FREE) | (nv & EN_FREE);
               end
               if (nv[B_SWRST]) begin
                  // Reset request discards the rest of the write
                  d.mainCtl[B_SWRST] = 1'b1;
                  d.syncPend[SY_SWRST] = 1'b1;
                  d.syncCnt = SYNC_CYCLES;
               end else begin
                  if (nv[B_ENABLE] != q.mainCtl[B_ENABLE]) begin
                     d.syncPend[SY_EN] = 1'b1;
                     d.syncCnt = SYNC_CYCLES;
                  end
                  d.mainCtl = nv;
               end
            end
            IDX_SEC: begin
               nv = mergeW(q.secCtl, pwdata, bm) & SEC_WMASK;
               if (q.mainCtl[B_ENABLE]) begin
                  nv = (q.secCtl & ~RXTX_MASK) | (nv & RXTX_MASK);
               end
               if ((nv & RXTX_MASK) != (q.secCtl & RXTX_MASK)) begin
                  d.syncPend[SY_SECONDARY_CONTROL] = 1'b1;
                  d.syncCnt = SYNC_CYCLES;
               end
               d.secCtl = nv;
            end
            IDX_BAUD: begin
               nv = mergeW({16'h0000, q.baud}, pwdata, bm);
               d.baud = nv[15:0];
            end
            IDX_RECEIVE_PULSE_LENGTH: begin
               nv = mergeW({24'h000000, q.receive_pulse_length}, pwdata, bm);
               d.receive_pulse_length = nv[7:0];
            end
            IDX_IEC: begin
               if (pstrb[0]) begin
                  d.irqEn = q.irqEn & ~(pwdata[7:0] & FLAG_MASK);
               end
            end
            IDX_IES: begin
               if (pstrb[0]) begin
                  d.irqEn = q.irqEn | (pwdata[7:0] & FLAG_MASK);
               end
            end
            IDX_FLAG: begin
               if (pstrb[0]) begin
                  d.irqFlag = q.irqFlag & ~pwdata[7:0];
               end
            end
            IDX_STAT: begin
               if (pstrb[0] && pwdata[ST_BUFOVF]) begin
                  d.bufOvf = 1'b0;
               end
            end
            IDX_DATA: begin
               // A full buffer ignores further data
               if (pstrb[0] && !q.txFull) begin
                  d.txBuf = pwdata[7:0];
                  d.txFull = 1'b1;
               end
            end
            IDX_DBG: begin
               if (pstrb[0]) begin
                  d.dbgStop = pwdata[0];
               end
            end
            default: d.mainCtl = q.mainCtl;
         endcase
      end
      if (done && !pwrite && !q.pslverr && idx == IDX_DATA) begin
         d.rxFull = 1'b0;
      end
      // Bit-rate divider, runs only while enabled
      if (q.coreEn) begin
         if (q.baudCnt == 16'h0000) begin
            tick = 1'b1;
            d.baudCnt = q.baud;
         end else begin
            d.baudCnt = q.baudCnt - 16'h0001;
         end
      end
      d.xckOe = q.coreEn & comm_mode_select;
      d.txdOe = q.coreEn & q.coreTx;
      // Frame engine
      case (q.state)
         ST_IDLE: begin
            d.xck = serial_clock_polarity;
            d.txd = 1'b1;
            if (tick && q.coreTx && q.txFull) begin
               txLoad = 1'b1;
               d.txFull = 1'b0;
               evt[F_DRE] = 1'b1;
               d.bitCnt = 4'd0;
               d.phase = 1'b0;
               d.state = comm_mode_select ? ST_DATA : ST_START;
               d.txd = comm_mode_select;
            end
         end
         ST_START: begin
            if (tick) begin
               d.txd = txBit;
               txShift = 1'b1;
               d.state = ST_DATA;
            end
         end
         ST_DATA: begin
            if (tick && comm_mode_select) begin
               if (!q.phase) begin
                  // Leading edge moves data out
                  d.xck = ~serial_clock_polarity;
                  d.txd = txBit;
                  txShift = 1'b1;
                  d.phase = 1'b1;
               end else begin
                  // Trailing edge samples the line
                  d.xck = serial_clock_polarity;
                  d.phase = 1'b0;
                  rxShift = q.coreRx;
                  evt[F_RXS] = q.coreRx && (q.bitCnt == 4'd0);
                  d.bitCnt = q.bitCnt + 4'd1;
                  if (q.bitCnt == 4'd7) begin
                     d.state = ST_STOP;
                  end
               end
            end else if (tick) begin
               d.bitCnt = q.bitCnt + 4'd1;
               if (q.bitCnt == 4'd7) begin
                  d.txd = 1'b1;
                  d.state = ST_STOP;
               end else begin
                  d.txd = txBit;
                  txShift = 1'b1;
               end
            end
         end
         ST_STOP: begin
            if (tick) begin
               d.state = ST_IDLE;
               evt[F_TXC] = 1'b1;
               if (comm_mode_select && q.coreRx) begin
                  if (q.rxFull) begin
                     d.bufOvf = 1'b1;
                     evt[F_ERR] = 1'b1;
                  end else begin
                     d.rxData = rxWord;
                     d.rxFull = 1'b1;
                     evt[F_RXC] = 1'b1;
                  end
               end
            end
         end
         default: d.state = ST_IDLE;
      endcase
      if (!q.coreEn) begin
         d.state = ST_IDLE;
      end
      // Handshake change seen on the filtered pin; masked until the
      // synchroniser settles, else its reset level reads as a change
      if (q.settle != PIN_SETTLE) begin
         d.settle = q.settle + 3'd1;
      end
      d.ctsLast = ctsS;
      evt[F_CLEAR_TO_SEND_CHANGE] = (q.settle == PIN_SETTLE) && (ctsS != q.ctsLast);
      // Set wins over a same-cycle clear
      d.irqFlag = d.irqFlag | evt;
      d.irq = |(d.irqFlag & d.irqEn);
      // Soft reset clears all core state but debug control and the bus answer
      keepRdy = d.pready;
      keepErr = d.pslverr;
      keepData = d.prdata;
      if (q.syncPend[SY_SWRST] && q.syncCnt == 3'd1) begin
         d = CORE_RST;
         d.dbgStop = q.dbgStop;
         // A bus answer due now still goes out, keeping the wait state fixed
         d.pready = keepRdy;
         d.pslverr = keepErr;
         d.prdata = keepData;
      end
   end

   // ****************************************
   // Registers
   // ****************************************
   always_ff @(posedge core_clk or posedge reset) begin
      if (reset) begin
         q <= CORE_RST;
      end else if (clkEn) begin
         q <= d;
      end
   end

   assign prdata = q.prdata;
   assign pready = q.pready;
   assign pslverr = q.pslverr;
   assign txd = q.txd;
   assign txdOe = q.txdOe;
   assign xck = q.xck;
   assign xckOe = q.xckOe;
   assign irq = q.irq;

   // ****************************************
   // Assertions
   // ****************************************
   default clocking cb @(posedge core_clk iff clkEn);
   endclocking
   default disable iff (reset);

   AST_ANSWER: assert property (answer |=> pready && !answer)
      else $error("no answer one cycle into access");
   AST_BYTELANE: assert property (done && pwrite && !pslverr && idx == IDX_BAUD
         && pstrb == 4'b0010 |=> q.baud[7:0] == $past(q.baud[7:0])
         && q.baud[15:8] == $past(pwdata[15:8]))
      else $error("byte lane write disturbed other lane");
   AST_ENPROT: assert property (done && pwrite && !pslverr && idx == IDX_SEC
         && q.mainCtl[B_ENABLE] |=> (q.secCtl & ~RXTX_MASK) == $past(q.secCtl & ~RXTX_MASK))
      else $error("protected field changed while enabled");
   AST_WPROT: assert property (answer && pwrite && wpS && idx == IDX_MAIN
         |=> pready && pslverr)
      else $error("locked write not refused");
   AST_SYNCDONE: assert property ($rose(q.syncPend[SY_EN]) |-> ##[1:4] !q.syncPend[SY_EN])
      else $error("sync delay did not end");
   AST_RSV31: assert property (pready && !pslverr && $past(idx) == IDX_MAIN
         |-> !prdata[31])
      else $error("reserved top bit read as one");
   AST_ORDER: assert property (txLoad |=> txBit == (bit_order_select ? $past(q.txBuf[0])
         : $past(q.txBuf[7])))
      else $error("first bit does not follow order bit");
   AST_POLSAMPLE: assert property (rxShift |=> xck == serial_clock_polarity)
      else $error("sample not on trailing edge");
   AST_POLCHANGE: assert property (txShift && comm_mode_select |=> xck != serial_clock_polarity)
      else $error("data change not on leading edge");
   AST_SWRST: assert property ($fell(q.syncPend[SY_SWRST]) |-> q.mainCtl == MAIN_RST)
      else $error("main control not zero after soft reset");
   AST_MODE: assert property (q.state == ST_START |-> !comm_mode_select ##0 !xckOe)
      else $error("start bit in synchronous mode");
   AST_IRQEN: assert property (done && pwrite && !pslverr && idx == IDX_IES && pstrb[0]
         |=> (q.irqEn & $past(pwdata[7:0] & FLAG_MASK)) == $past(pwdata[7:0] & FLAG_MASK))
      else $error("enable set bit landed elsewhere");

   COV_SYNCFRAME: cover property (txLoad && comm_mode_select);
   COV_RXC: cover property (evt[F_RXC]);
   COV_ERRANS: cover property (pready && pslverr);
   COV_SWRST: cover property ($fell(q.syncPend[SY_SWRST]));
endmodule : usr_usart
`default_nettype wire

// file: verification/usr_far_end.sv
// Purpose: Far-end synchronous serial partner of the unit.
// Assumes: Unit drives xck and txd in synchronous mode.
// Notes:   Sends reply MSB first; captures txd into got.
`timescale 1ns/1ps
`default_nettype none
module usr_far_end (
   input wire logic xck,
   input wire logic xckOe,
   input wire logic txd,
   input wire logic pol,
   input wire logic [7:0] reply,
   output logic rxd,
   output logic [7:0] got
);
   // ****************************************
   // Serial edges
   // ****************************************
   int cnt = 0;
   initial begin
      rxd = 1'b1;
      got = 8'h00;
   end
   // Trailing edge samples, leading edge launches the next reply bit
   always @(posedge xck or negedge xck) begin
      if (xckOe === 1'b1 && xck === pol) begin
         got <= {got[6:0], txd};
      end else if (xckOe === 1'b1) begin
         rxd <= (cnt < 8) ? reply[7 - cnt] : ~rxd;
         cnt = cnt + 1;
      end
   end
   // Released line must not keep a stale bit
   always @(negedge xckOe) begin
      rxd <= ~rxd;
      cnt = 0;
   end
endmodule : usr_far_end
`default_nettype wire

// file: verification/tb.sv
// Purpose: Register and synchronous frame tests of the serial unit.
// Assumes: Baud divider seven, slower than the pin synchroniser.
// Notes:   Partner answers with a fixed reply byte.
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin tests_run++; if ((g) !== (e)) begin fails++; \
   $display("mismatch %s exp %0h got %0h", nm, e, g); end end
module tb;
   import usr_pkg::*;
   // ****************************************
   // Signals and instances
   // ****************************************
   logic core_clk = 0, reset = 1, psel = 0, penable = 0, pwrite = 0, lockPin = 0, pol = 0;
   logic [7:0] paddr = 0, got, dat;
   logic [31:0] pwdata = 0, prdata, rd, cfg;
   logic [3:0] pstrb = 0;
   logic pready, pslverr, rxd, txd, txdOe, xck, xckOe, irq, er;
   int fails = 0, tests_run = 0;
   usr_usart i_dut (.core_clk(core_clk), .reset(reset), .clkEn(1'b1), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
      .prdata(prdata), .pready(pready), .pslverr(pslverr), .rxd(rxd), .ctsPin(1'b1),
      .periphAccessLock(lockPin), .txd(txd), .txdOe(txdOe), .xck(xck), .xckOe(xckOe),
      .irq(irq));
   usr_far_end i_far (.xck(xck), .xckOe(xckOe), .txd(txd), .pol(pol), .reply(8'h1b),
      .rxd(rxd), .got(got));
   // ****************************************
   // Clock, watchdog and tasks
   // ****************************************
   initial forever #4 core_clk = ~core_clk;
   // Whole run needs well under this many cycles
   initial begin
      repeat (20000) @(posedge core_clk);
      fails++;
      finish_test();
   end
   // One APB transfer, held until pready is sampled high
   task automatic apb(input logic w, input logic [5:0] idx, input logic [31:0] d,
      input logic [3:0] s);
      @(posedge core_clk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= {idx, 2'b00};
      pwdata <= d;
      pstrb <= s;
      @(posedge core_clk);
      penable <= 1'b1;
      do @(posedge core_clk); while (pready !== 1'b1);
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb
   function automatic logic [7:0] rev8(input logic [7:0] v);
      for (int i = 0; i < 8; i++) rev8[i] = v[7 - i];
   endfunction : rev8
   task automatic finish_test;
      $display("Comparisons %0d mismatches %0d", tests_run, fails);
      if (fails == 0 && tests_run > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask : finish_test
   // ****************************************
   // Test sequence
   // ****************************************
   initial begin
      repeat (20) @(posedge core_clk);
      reset <= 1'b0;
      apb(0, IDX_MAIN, 0, 4'hf);
      `CHK("main reset", 32'h0, rd)
      apb(0, 6'h02, 0, 4'hf);
      `CHK("unmapped", 1'b1, er)
      apb(1, IDX_MAIN, 32'h40000000, 4'h8);
      apb(1, IDX_MAIN, 32'hffffffff, 4'h4);
      apb(0, IDX_MAIN, 0, 4'hf);
      `CHK("lanes", (MAIN_WMASK & 32'h00ff0000) | 32'h40000000, rd)
      // Lock needs a few cycles through the pin synchroniser
      lockPin <= 1'b1;
      repeat (6) @(posedge core_clk);
      apb(1, IDX_MAIN, 0, 4'hf);
      `CHK("lock err", 1'b1, er)
      lockPin <= 1'b0;
      repeat (6) @(posedge core_clk);
      apb(0, IDX_MAIN, 0, 4'hf);
      `CHK("lock kept", 32'h40f30000 & (MAIN_WMASK | 32'h40000000), rd)
      apb(1, IDX_SEC, RXTX_MASK, 4'hf);
      // Lane writes leave a divider of seven for the frames
      apb(1, IDX_BAUD, 32'hffff, 4'hf);
      apb(1, IDX_BAUD, 32'h7, 4'h1);
      apb(1, IDX_BAUD, 32'hff, 4'h2);
      apb(0, IDX_BAUD, 0, 4'hf);
      `CHK("baud lanes", 32'h7, rd)
      apb(1, IDX_IES, 32'h2, 4'h1);
      // Every order and polarity in synchronous mode
      for (int k = 0; k < 4; k++) begin
         dat = 8'h4d + 8'(k);
         pol <= k[0];
         cfg = {1'b0, k[1], k[0], 1'b1, 28'h0};
         apb(1, IDX_MAIN, 0, 4'hf);
         repeat (8) @(posedge core_clk);
         apb(1, IDX_MAIN, cfg, 4'hf);
         apb(1, IDX_MAIN, cfg | 32'h2, 4'hf);
         #1 `CHK("txdOe early", 1'b0, txdOe)
         repeat (8) @(posedge core_clk);
         `CHK("txdOe", 1'b1, txdOe)
         `CHK("xckOe", 1'b1, xckOe)
         `CHK("xck idle", k[0], xck)
         apb(0, IDX_SYNC, 0, 4'hf);
         `CHK("sync idle", 32'h0, rd)
         apb(1, IDX_MAIN, (cfg ^ 32'h40000000) | 32'h2, 4'hf);
         apb(0, IDX_MAIN, 0, 4'hf);
         `CHK("protected", cfg | 32'h2, rd)
         apb(1, IDX_SEC, 32'hffffffff, 4'hf);
         apb(0, IDX_SEC, 0, 4'hf);
         `CHK("sec protected", RXTX_MASK, rd)
         apb(1, IDX_DATA, {24'h0, dat}, 4'h1);
         for (int n = 0; n < 400 && irq !== 1'b1; n++) @(posedge core_clk);
         `CHK("tx bits", k[1] ? rev8(dat) : dat, got)
         apb(0, IDX_FLAG, 0, 4'hf);
         `CHK("flags", 8'h06, rd[7:0] & 8'h06)
         apb(0, IDX_DATA, 0, 4'hf);
         `CHK("rx bits", k[1] ? rev8(8'h1b) : 8'h1b, rd[7:0])
         apb(1, IDX_FLAG, 32'hff, 4'h1);
         repeat (2) @(posedge core_clk);
         `CHK("irq clear", 1'b0, irq)
      end
      // Asynchronous frame: no serial clock, transmit only
      apb(1, IDX_MAIN, 0, 4'hf);
      repeat (8) @(posedge core_clk);
      apb(1, IDX_MAIN, 32'h2, 4'hf);
      repeat (8) @(posedge core_clk);
      `CHK("async xckOe", 1'b0, xckOe)
      apb(1, IDX_DATA, 32'h3c, 4'h1);
      for (int n = 0; n < 400 && irq !== 1'b1; n++) @(posedge core_clk);
      apb(0, IDX_FLAG, 0, 4'hf);
      `CHK("async flags", 8'h02, rd[7:0] & 8'h06)
      // Soft reset returns the map, all but the debug register, to its reset values
      apb(1, IDX_MAIN, 32'h1, 4'h1);
      repeat (4) @(posedge core_clk);
      apb(0, IDX_MAIN, 0, 4'hf);
      `CHK("soft reset main", 32'h0, rd)
      apb(0, IDX_IES, 0, 4'hf);
      `CHK("soft reset enables", 32'h0, rd)
      finish_test();
   end
endmodule : tb
`default_nettype wire
